// [boot_isp_pkg.sv]
// Purpose: Shared constants and types for the boot selector and serial record loader
// Assumes: APB byte addresses, 8-bit ASCII characters, 16-bit program addresses
// Notes: Register offsets and status bit positions are local choices
package boot_isp_pkg;
  // Boot addresses
  localparam logic [15:0] USER_START = 16'h0000;
  localparam logic [15:0] BOOT_ENTRY = 16'hfc03;
  localparam logic [15:0] LOADER_BASE = 16'hfc00;
  localparam logic [15:0] LOADER_TOP = 16'hffff;
  localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
  // Register offsets
  localparam logic [7:0] OFS_SEC = 8'h00;
  localparam logic [7:0] OFS_BSTAT = 8'h04;
  localparam logic [7:0] OFS_VEC = 8'h08;
  localparam logic [7:0] OFS_LOCK = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Reset values and fields
  localparam logic [7:0] SEC_RESET = 8'h18;
  localparam int JUMP_BIT = 0;
  localparam logic [7:0] BSTAT_RESET = 8'hff;
  localparam logic [7:0] BSTAT_BUSY = 8'hff;
  localparam logic [7:0] BSTAT_DONE = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'hfc;
  localparam logic LOCK_RESET = 1'b1;
  localparam int ST_BAUD_BIT = 16;
  localparam int ST_FAIL_BIT = 17;
  localparam int ST_BOOT_BIT = 18;
  // Characters
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_R = 8'h52;
  // Records
  localparam logic [7:0] REC_DATA = 8'h00;
  localparam logic [7:0] REC_EOF = 8'h01;
  localparam logic [7:0] REC_OSC = 8'h02;
  localparam logic [7:0] MAX_DATA = 8'h10;
  localparam logic [4:0] HDR_BYTES = 5'h04;
  // Serial framing
  localparam logic [3:0] RX_STOP_BIT = 4'h9;
  localparam logic [3:0] TX_BITS = 4'ha;
  typedef enum logic [1:0] {AB_IDLE, AB_MEAS, AB_SKIP, AB_DONE} baud_e;
  typedef enum logic [2:0] {P_COLON, P_HEX, P_EOL, P_EXEC, P_PROG} parse_e;
endpackage

// [boot_isp_loader.sv]
// Functional notes
// - At reset release without strap, jump bit set starts 0000h, else FC03h.
// - From boot entry, zero boot status byte sends execution to 0000h.
// - Nonzero status byte starts at software boot vector high, 00h low.
// - Software boot vector resets to FCh, giving loader entry FC00h.
// - Loader region FC00h-FFFFh is top kilobyte and can be locked.
// - Strap store-strobe low, access high, latch high forces loader at FC00h.
// - Status byte set before programming, cleared only after successful completion.
// - First character U measures one bit time to set the baud divider.
// - Every received character is echoed back.
// - After baud lock only colon-prefixed hex records ending CR LF accepted; code waits only for LF, CR is not checked.
// - Record data count at most 16, all counts to 16 supported.
// - Record buffered and checksum compared before anything executes.
// - Checksum mismatch answers X and skips the record.
// - Correctly executed record answers with a period.
// - Data record programs bytes consecutively from record address.
// - Data record answers period only if all bytes programmed, else R.
// - End-of-file record checked, no operation, count and address ignored; code answers X when the count is above 16.
// - Oscillator record accepted with one don't-care byte and ignored.
//
// Purpose: Boot address selection at reset release and serial hex record loader
// Assumes: Inputs synchronous to pclk; program port answers each request with prog_done
// Notes: Boot bytes live in flops here, so they return to defaults on every reset
`timescale 1ns/10ps
module boot_isp_loader #(
  parameter int BAUD_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset straps
  input wire logic program_store_strobe_n,
  input wire logic external_access_pin,
  input wire logic addr_latch_strobe,
  // Boot result
  output logic boot_valid,
  output logic [15:0] boot_entry_addr,
  output logic [15:0] boot_start_addr,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Program memory write port
  output logic prog_req,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_wdata,
  input wire logic prog_done,
  input wire logic prog_err
);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] bstat;
    logic [7:0] vec;
    logic lock;
    logic boot_valid;
    logic strap_cap;
    logic jump_cap;
    logic [7:0] bstat_cap;
    logic [7:0] vec_cap;
    logic [15:0] entry;
    logic [15:0] start;
    boot_isp_pkg::baud_e ab;
    logic [BAUD_W-1:0] bit_cycles;
    logic [BAUD_W-1:0] ab_cnt;
    logic rx_busy;
    logic [BAUD_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic tx_busy;
    logic [BAUD_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
    logic echo_pend;
    logic [7:0] echo_ch;
    logic rep_pend;
    logic [7:0] rep_ch;
    boot_isp_pkg::parse_e st;
    logic nib_lo;
    logic [3:0] nib_hi;
    logic [4:0] idx;
    logic [7:0] cnt;
    logic too_long;
    logic [15:0] addr;
    logic [7:0] rtype;
    logic [7:0] sum;
    logic [15:0][7:0] buffer;
    logic [3:0] pidx;
    logic rec_fail;
    logic upd_active;
    logic upd_fail;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Returns {valid, nibble} for an ASCII hex digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      v = {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      v = {1'b1, c[3:0] + 4'h9};
    end
    return v;
  endfunction

  function automatic logic in_loader(input logic [15:0] a);
    return a >= boot_isp_pkg::LOADER_BASE && a <= boot_isp_pkg::LOADER_TOP;
  endfunction

  logic apb_wr;
  logic rx_done;
  logic [4:0] hv;
  logic [7:0] rx_byte;
  logic [15:0] pa;
  logic blocked;

  localparam logic [3:0] TX_LAST = boot_isp_pkg::TX_BITS - 4'h1;

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pa = state_reg.addr + {12'h000, state_reg.pidx};
  assign blocked = state_reg.lock && in_loader(pa);

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    case (paddr)
      boot_isp_pkg::OFS_SEC: prdata = {24'h000000, state_reg.sec};
      boot_isp_pkg::OFS_BSTAT: prdata = {24'h000000, state_reg.bstat};
      boot_isp_pkg::OFS_VEC: prdata = {24'h000000, state_reg.vec};
      boot_isp_pkg::OFS_LOCK: prdata = {31'h0000_0000, state_reg.lock};
      boot_isp_pkg::OFS_STATUS: begin
        prdata[15:0] = state_reg.start;
        prdata[boot_isp_pkg::ST_BAUD_BIT] = state_reg.ab == boot_isp_pkg::AB_DONE;
        prdata[boot_isp_pkg::ST_FAIL_BIT] = state_reg.upd_fail;
        prdata[boot_isp_pkg::ST_BOOT_BIT] = state_reg.boot_valid;
      end
      default: pslverr = psel && penable;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    rx_done = 1'b0;
    rx_byte = state_reg.rx_sh;
    hv = 5'h00;

    // Register writes; hardware updates further down take priority
    if (apb_wr) begin
      case (paddr)
        boot_isp_pkg::OFS_SEC: state_next.sec = pwdata[7:0];
        boot_isp_pkg::OFS_BSTAT: state_next.bstat = pwdata[7:0];
        boot_isp_pkg::OFS_VEC: state_next.vec = pwdata[7:0];
        boot_isp_pkg::OFS_LOCK: state_next.lock = pwdata[0];
        default: state_next.lock = state_reg.lock;
      endcase
    end

    // Boot decision taken once, in the first cycle after reset release
    if (!state_reg.boot_valid) begin
      state_next.boot_valid = 1'b1;
      state_next.strap_cap = !program_store_strobe_n && external_access_pin
                             && addr_latch_strobe;
      state_next.jump_cap = state_reg.sec[boot_isp_pkg::JUMP_BIT];
      state_next.bstat_cap = state_reg.bstat;
      state_next.vec_cap = state_reg.vec;
      if (state_next.strap_cap) begin
        state_next.entry = boot_isp_pkg::BOOT_ENTRY;
        state_next.start = {boot_isp_pkg::VEC_RESET, boot_isp_pkg::LOW_BYTE_ZERO};
      end else if (state_next.jump_cap) begin
        state_next.entry = boot_isp_pkg::USER_START;
        state_next.start = boot_isp_pkg::USER_START;
      end else begin
        state_next.entry = boot_isp_pkg::BOOT_ENTRY;
        if (state_reg.bstat == 8'h00) begin
          state_next.start = boot_isp_pkg::USER_START;
        end else begin
          state_next.start = {state_reg.vec, boot_isp_pkg::LOW_BYTE_ZERO};
        end
      end
    end

    // Autobaud: the low start bit of U is exactly one bit time
    case (state_reg.ab)
      boot_isp_pkg::AB_IDLE: begin
        if (!rxd) begin
          state_next.ab = boot_isp_pkg::AB_MEAS;
          state_next.ab_cnt = {{(BAUD_W-1){1'b0}}, 1'b1};
        end
      end
      boot_isp_pkg::AB_MEAS: begin
        if (rxd) begin
          state_next.bit_cycles = state_reg.ab_cnt;
          state_next.ab_cnt = '0;
          state_next.ab = boot_isp_pkg::AB_SKIP;
        end else if (state_reg.ab_cnt != '1) begin
          state_next.ab_cnt = state_reg.ab_cnt + 1'b1;
        end
      end
      boot_isp_pkg::AB_SKIP: begin
        // U alternates bits, so two idle bit times mean its stop bit has passed
        if (!rxd) begin
          state_next.ab_cnt = '0;
        end else if (state_reg.ab_cnt == {state_reg.bit_cycles[BAUD_W-2:0], 1'b0}) begin
          state_next.ab = boot_isp_pkg::AB_DONE;
          state_next.echo_pend = 1'b1;
          state_next.echo_ch = boot_isp_pkg::CH_U;
        end else begin
          state_next.ab_cnt = state_reg.ab_cnt + 1'b1;
        end
      end
      boot_isp_pkg::AB_DONE: state_next.ab = boot_isp_pkg::AB_DONE;
      default: state_next.ab = boot_isp_pkg::AB_IDLE;
    endcase

    // Receiver, sampling mid-bit at the measured rate
    if (state_reg.ab == boot_isp_pkg::AB_DONE) begin
      if (!state_reg.rx_busy) begin
        if (!rxd) begin
          state_next.rx_busy = 1'b1;
          state_next.rx_cnt = state_reg.bit_cycles >> 1;
          state_next.rx_bit = 4'h0;
        end
      end else if (state_reg.rx_cnt != '0) begin
        state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
      end else begin
        state_next.rx_cnt = state_reg.bit_cycles - 1'b1;
        state_next.rx_bit = state_reg.rx_bit + 4'h1;
        if (state_reg.rx_bit == 4'h0 && rxd) begin
          state_next.rx_busy = 1'b0;
        end else if (state_reg.rx_bit == boot_isp_pkg::RX_STOP_BIT) begin
          state_next.rx_busy = 1'b0;
          rx_done = 1'b1;
        end else if (state_reg.rx_bit != 4'h0) begin
          state_next.rx_sh = {rxd, state_reg.rx_sh[7:1]};
        end
      end
    end

    // Transmitter: echo goes ahead of the answer
    if (!state_reg.tx_busy) begin
      state_next.txd = 1'b1;
      if (state_reg.echo_pend || state_reg.rep_pend) begin
        state_next.tx_busy = 1'b1;
        state_next.tx_bit = 4'h0;
        state_next.tx_cnt = state_reg.bit_cycles - 1'b1;
        state_next.txd = 1'b0;
        if (state_reg.echo_pend) begin
          state_next.echo_pend = 1'b0;
          state_next.tx_sh = {1'b1, state_reg.echo_ch, 1'b0};
        end else begin
          state_next.rep_pend = 1'b0;
          state_next.tx_sh = {1'b1, state_reg.rep_ch, 1'b0};
        end
      end
    end else if (state_reg.tx_cnt != '0) begin
      state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
    end else begin
      state_next.tx_cnt = state_reg.bit_cycles - 1'b1;
      state_next.tx_sh = {1'b1, state_reg.tx_sh[9:1]};
      state_next.txd = state_reg.tx_sh[1];
      state_next.tx_bit = state_reg.tx_bit + 4'h1;
      if (state_reg.tx_bit == TX_LAST) begin
        state_next.tx_busy = 1'b0;
        state_next.txd = 1'b1;
      end
    end

    if (rx_done) begin
      // A character arriving before the last echo left overwrites it
      state_next.echo_pend = 1'b1;
      state_next.echo_ch = rx_byte;
    end

    // Record parser
    case (state_reg.st)
      boot_isp_pkg::P_COLON: begin
        if (rx_done && rx_byte == boot_isp_pkg::CH_COLON) begin
          state_next.st = boot_isp_pkg::P_HEX;
          state_next.idx = 5'h00;
          state_next.sum = 8'h00;
          state_next.nib_lo = 1'b0;
          state_next.too_long = 1'b0;
        end
      end
      boot_isp_pkg::P_HEX: begin
        if (rx_done) begin
          hv = hex_val(rx_byte);
          if (!hv[4]) begin
            state_next.st = boot_isp_pkg::P_COLON;
          end else if (!state_reg.nib_lo) begin
            state_next.nib_hi = hv[3:0];
            state_next.nib_lo = 1'b1;
          end else begin
            rx_byte = {state_reg.nib_hi, hv[3:0]};
            state_next.nib_lo = 1'b0;
            state_next.sum = state_reg.sum + rx_byte;
            state_next.idx = state_reg.idx + 5'h01;
            case (state_reg.idx)
              5'h00: begin
                state_next.cnt = rx_byte;
                state_next.too_long = rx_byte > boot_isp_pkg::MAX_DATA;
              end
              5'h01: state_next.addr[15:8] = rx_byte;
              5'h02: state_next.addr[7:0] = rx_byte;
              5'h03: begin
                state_next.rtype = rx_byte;
                if (state_reg.cnt == 8'h00 || state_reg.too_long) begin
                  state_next.idx = boot_isp_pkg::HDR_BYTES + 5'h10;
                end
              end
              default: begin
                if (state_reg.idx < boot_isp_pkg::HDR_BYTES + 5'h10
                    && {3'h0, state_reg.idx - boot_isp_pkg::HDR_BYTES} < state_reg.cnt) begin
                  state_next.buffer[4'(state_reg.idx - boot_isp_pkg::HDR_BYTES)] = rx_byte;
                  if ({3'h0, state_next.idx - boot_isp_pkg::HDR_BYTES} == state_reg.cnt) begin
                    state_next.idx = boot_isp_pkg::HDR_BYTES + 5'h10;
                  end
                end else begin
                  state_next.st = boot_isp_pkg::P_EOL;
                end
              end
            endcase
          end
        end
      end
      boot_isp_pkg::P_EOL: begin
        if (rx_done && rx_byte == boot_isp_pkg::CH_LF) begin
          state_next.st = boot_isp_pkg::P_EXEC;
        end else if (rx_done && rx_byte == boot_isp_pkg::CH_COLON) begin
          state_next.st = boot_isp_pkg::P_COLON;
        end
      end
      boot_isp_pkg::P_EXEC: begin
        state_next.st = boot_isp_pkg::P_COLON;
        state_next.rep_pend = 1'b1;
        state_next.rep_ch = boot_isp_pkg::CH_DOT;
        if (state_reg.sum != 8'h00 || state_reg.too_long) begin
          state_next.rep_ch = boot_isp_pkg::CH_X;
        end else begin
          case (state_reg.rtype)
            boot_isp_pkg::REC_DATA: begin
              if (state_reg.cnt != 8'h00) begin
                state_next.rep_pend = 1'b0;
                state_next.st = boot_isp_pkg::P_PROG;
                state_next.pidx = 4'h0;
                state_next.rec_fail = 1'b0;
                if (!state_reg.upd_active) begin
                  state_next.upd_active = 1'b1;
                  state_next.upd_fail = 1'b0;
                  state_next.bstat = boot_isp_pkg::BSTAT_BUSY;
                end
              end
            end
            boot_isp_pkg::REC_EOF: begin
              state_next.upd_active = 1'b0;
              if (state_reg.upd_active && !state_reg.upd_fail) begin
                state_next.bstat = boot_isp_pkg::BSTAT_DONE;
              end
            end
            boot_isp_pkg::REC_OSC: state_next.rep_ch = boot_isp_pkg::CH_DOT;
            default: state_next.rep_ch = boot_isp_pkg::CH_X;
          endcase
        end
      end
      boot_isp_pkg::P_PROG: begin
        if (blocked || prog_done) begin
          state_next.rec_fail = state_reg.rec_fail || blocked || prog_err;
          state_next.pidx = state_reg.pidx + 4'h1;
          if ({4'h0, state_reg.pidx} + 8'h01 == state_reg.cnt) begin
            state_next.st = boot_isp_pkg::P_COLON;
            state_next.rep_pend = 1'b1;
            if (state_next.rec_fail) begin
              state_next.rep_ch = boot_isp_pkg::CH_R;
              state_next.upd_fail = 1'b1;
            end else begin
              state_next.rep_ch = boot_isp_pkg::CH_DOT;
            end
          end
        end
      end
      default: state_next.st = boot_isp_pkg::P_COLON;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.sec <= boot_isp_pkg::SEC_RESET;
      state_reg.bstat <= boot_isp_pkg::BSTAT_RESET;
      state_reg.vec <= boot_isp_pkg::VEC_RESET;
      state_reg.lock <= boot_isp_pkg::LOCK_RESET;
      state_reg.txd <= 1'b1;
      state_reg.ab <= boot_isp_pkg::AB_IDLE;
      state_reg.st <= boot_isp_pkg::P_COLON;
    end else begin
      state_reg <= state_next;
    end
  end

  assign boot_valid = state_reg.boot_valid;
  assign boot_entry_addr = state_reg.entry;
  assign boot_start_addr = state_reg.start;
  assign txd = state_reg.txd;
  assign prog_req = state_reg.st == boot_isp_pkg::P_PROG && !blocked;
  assign prog_addr = pa;
  assign prog_wdata = state_reg.buffer[state_reg.pidx];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_boot_taken;
    $rose(state_reg.boot_valid);
  endsequence
  sequence s_bad_exec;
    state_reg.st == boot_isp_pkg::P_EXEC && state_reg.sum != 8'h00;
  endsequence

  chk_jump_start: assert property (s_boot_taken and state_reg.jump_cap && !state_reg.strap_cap
    |-> boot_start_addr == 16'h0000 && boot_entry_addr == 16'h0000)
    else $error("jump bit did not start at user code");
  chk_boot_entry: assert property (s_boot_taken and !state_reg.jump_cap && !state_reg.strap_cap
    |-> boot_entry_addr == 16'hfc03)
    else $error("cleared jump bit did not enter boot code");
  chk_zero_status: assert property (s_boot_taken and !state_reg.jump_cap && !state_reg.strap_cap
    && state_reg.bstat_cap == 8'h00 |-> boot_start_addr == 16'h0000)
    else $error("zero status byte did not start user code");
  chk_vector_start: assert property (s_boot_taken and !state_reg.jump_cap && !state_reg.strap_cap
    && state_reg.bstat_cap != 8'h00 |-> boot_start_addr == {state_reg.vec_cap, 8'h00})
    else $error("start address not built from boot vector");
  chk_strap_force: assert property (s_boot_taken and state_reg.strap_cap
    |-> boot_start_addr == 16'hfc00)
    else $error("strap did not force loader start");
  chk_bad_sum: assert property (s_bad_exec |=> state_reg.rep_pend && state_reg.rep_ch == 8'h58
    && state_reg.st == boot_isp_pkg::P_COLON && !prog_req)
    else $error("checksum error not answered with X");
  chk_echo_char: assert property (rx_done |=> state_reg.echo_pend
    && state_reg.echo_ch == $past(state_reg.rx_sh))
    else $error("received character not queued for echo");
  chk_prog_bound: assert property (prog_req |-> {4'h0, state_reg.pidx} < state_reg.cnt
    && state_reg.cnt <= 8'h10)
    else $error("programming past record count");
  chk_loader_lock: assert property (prog_req |-> !(state_reg.lock && prog_addr >= 16'hfc00))
    else $error("locked loader region written");
  chk_fail_answer: assert property (state_reg.st == boot_isp_pkg::P_PROG && prog_done && prog_err
    && {4'h0, state_reg.pidx} + 8'h01 == state_reg.cnt |=> state_reg.rep_ch == 8'h52)
    else $error("failed byte not answered with R");

endmodule

// [mem_model.sv]
// Purpose: Program memory behind the loader's byte write port
// Assumes: One byte per request, answered by a one-cycle done pulse
// Notes: Alternates prompt and slow answers; fail makes every byte report an error
`timescale 1ns/10ps
module mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  output logic prog_done,
  output logic prog_err,
  // Bench control and observation
  input wire logic fail,
  output int nreq
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;
  logic slow;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_done <= 1'b0;
      prog_err <= 1'b0;
      wait_cnt <= 2'd0;
      slow <= 1'b0;
      nreq <= 0;
    end else begin
      prog_done <= 1'b0;
      // Error flag means nothing outside a done pulse, so it keeps moving
      prog_err <= ~prog_err;
      if (prog_req && !prog_done) begin
        if (wait_cnt == 2'd0) begin
          prog_done <= 1'b1;
          prog_err <= fail;
          nreq <= nreq + 1;
          slow <= ~slow;
          wait_cnt <= slow ? 2'd0 : 2'd3;
          if (!fail) mem[prog_addr] <= prog_wdata;
        end else begin
          wait_cnt <= wait_cnt - 2'd1;
        end
      end
    end
  end
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the boot selector and serial record loader
// Assumes: Host bit time of 16 clocks; host waits for each echo before the next character
// Notes: Boot bytes return to defaults on reset, so only the default boot paths are reachable
`timescale 1ns/10ps
module tb;
  localparam int B = 16;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00, prog_wdata, s;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic strobe_n = 0, ext_acc = 1, ale = 1, boot_valid, rxd = 1, txd, e;
  logic [15:0] entry, start, prog_addr;
  logic prog_req, prog_done, prog_err, fail = 0;
  int nreq, err_total = 0, cmp_count = 0;
  always #2.5 pclk = ~pclk;
  boot_isp_loader boot_isp_loader_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .program_store_strobe_n(strobe_n),
    .external_access_pin(ext_acc), .addr_latch_strobe(ale), .boot_valid(boot_valid),
    .boot_entry_addr(entry), .boot_start_addr(start), .rxd(rxd), .txd(txd),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_done(prog_done), .prog_err(prog_err));
  mem_model mem_model_inst (.pclk(pclk), .presetn(presetn), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_done(prog_done),
    .prog_err(prog_err), .fail(fail), .nreq(nreq));
  task give_verdict;
    $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      err_total++;
      give_verdict;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic recv(output logic [7:0] c);
    int n;
    n = 0;
    while (txd !== 1'b0) begin
      @(negedge pclk);
      n++;
      if (n > 4000) begin
        err_total++;
        give_verdict;
      end
    end
    // Serial output is read on the falling edge, away from the edge that launches it
    repeat (B / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (B) @(negedge pclk);
      c[i] = txd;
    end
    repeat (B) @(negedge pclk);
    @(posedge pclk);
  endtask
  task automatic tx(input logic [7:0] c);
    logic [7:0] got;
    logic [8:0] f;
    f = {c, 1'b0};
    for (int i = 0; i < 9; i++) begin
      rxd <= f[i];
      repeat (B) @(posedge pclk);
    end
    rxd <= 1'b1;
    recv(got);
    chk(got, c);
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  task sb(input logic [7:0] b);
    tx(hx(b[7:4]));
    tx(hx(b[3:0]));
    s = s + b;
  endtask
  // Sends one whole record, corrupting the checksum by bad, and checks the answer
  task automatic rec(input logic [7:0] n, input logic [15:0] a, input logic [7:0] t,
                     input logic [7:0] bad, input logic [7:0] ans);
    logic [7:0] got;
    s = 8'h00;
    tx(":");
    sb(n);
    sb(a[15:8]);
    sb(a[7:0]);
    sb(t);
    for (int i = 0; i < n; i++) sb(a[7:0] + 8'(i));
    sb((8'h00 - s) ^ bad);
    tx(8'h0d);
    tx(8'h0a);
    recv(got);
    chk(got, ans);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(boot_valid, 1);
    chk(start, 32'hfc00);
    strobe_n <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(entry, 32'hfc03);
    chk(start, 32'hfc00);
    rd(8'h00, 32'h18);
    rd(8'h04, 32'hff);
    rd(8'h08, 32'hfc);
    rd(8'h0c, 32'h1);
    rd(8'h20, 32'h0);
    chk(e, 1);
    tx("U");
    apb(1'b0, 8'h10, 32'h0);
    chk(r[16], 1);
    rec(8'h10, 16'h0040, 8'h00, 8'h00, ".");
    for (int i = 0; i < 16; i++) chk(mem_model_inst.mem[16'h0040 + i], 8'h40 + i);
    rd(8'h04, 32'hff);
    rec(8'h02, 16'h0060, 8'h00, 8'h01, "X");
    rec(8'h11, 16'h0070, 8'h00, 8'h00, "X");
    chk(nreq, 16);
    rec(8'h01, 16'h0000, 8'h02, 8'h00, ".");
    rec(8'h00, 16'h1234, 8'h01, 8'h00, ".");
    rd(8'h04, 32'h0);
    fail <= 1'b1;
    rec(8'h01, 16'h0080, 8'h00, 8'h00, "R");
    rd(8'h04, 32'hff);
    fail <= 1'b0;
    rec(8'h01, 16'hfc10, 8'h00, 8'h00, "R");
    chk(nreq, 17);
    rec(8'h00, 16'h0000, 8'h01, 8'h00, ".");
    rd(8'h04, 32'hff);
    apb(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h0);
    give_verdict;
  end
endmodule
